// [rtl/phx_unit.sv]
`timescale 1ns/10ps
module phx_unit (
	// clock and reset
	input  wire logic            i_ref_clk,
	input  wire logic            i_sys_rst,
	// request
	input  wire logic            i_start,
	input  wire phx_pkg::phx_op_t i_op,
	input  wire logic [15:0]     i_ctrl,
	input  wire logic [511:0]    i_src_words,
	input  wire logic [15:0]     i_text_src,
	input  wire logic [15:0]     i_result_prev,
	input  wire logic [47:0]     i_dest_prev,
	// answer
	output logic                 o_done,
	output logic [15:0]          o_result,
	output logic [47:0]          o_dest,
	output logic                 o_conversion_error_flag
);

	// lowest or highest set bit position of a 16-bit word
	function automatic logic [3:0] pos16(input logic [15:0] w, input logic hi);
		logic [3:0] p;
		p = 4'h0;
		for (int k = 0; k < 16; k++) begin
			if (w[k] && (hi || (p == 4'h0 && !w[0] && k != 0) || (!hi && k == 0)))
				p = 4'(k);
		end
		if (!hi) begin
			p = 4'h0;
			for (int k = 15; k >= 0; k--) begin
				if (w[k])
					p = 4'(k);
			end
		end
		return p;
	endfunction

	// set bit position within a 256-bit field
	function automatic logic [7:0] pos256(input logic [255:0] f, input logic hi);
		logic [7:0] p;
		p = 8'h00;
		if (hi) begin
			for (int k = 0; k < 256; k++) begin
				if (f[k])
					p = 8'(k);
			end
		end else begin
			for (int k = 255; k >= 0; k--) begin
				if (f[k])
					p = 8'(k);
			end
		end
		return p;
	endfunction

	// hex digit to character with parity
	function automatic logic [7:0] to_chr(input logic [3:0] d, input logic [3:0] par);
		logic [7:0] c;
		c = (d < 4'ha) ? (phx_pkg::CHR_DIGIT_BASE + 8'(d)) : (phx_pkg::CHR_LETTER_BASE + 8'(d));
		if (par == phx_pkg::PAR_EVEN)
			c[7] = ^c[6:0];
		else if (par == phx_pkg::PAR_ODD)
			c[7] = ~^c[6:0];
		else
			c[7] = 1'b0;
		return c;
	endfunction

	// control fields
	wire logic [3:0] f_start = i_ctrl[phx_pkg::ENC_START_LSB +: 4];
	wire logic [3:0] f_count = i_ctrl[phx_pkg::ENC_COUNT_LSB +: 4];
	wire logic [3:0] f_dir   = i_ctrl[phx_pkg::ENC_DIR_LSB +: 4];
	wire logic [3:0] f_mode  = i_ctrl[phx_pkg::ENC_MODE_LSB +: 4];
	wire logic       dir_hi  = f_dir[0];

	// designator fields
	wire logic [3:0] t_digit = i_ctrl[phx_pkg::TXT_DIGIT_LSB +: 4];
	wire logic [3:0] t_count = i_ctrl[phx_pkg::TXT_COUNT_LSB +: 4];
	wire logic [3:0] t_byte  = i_ctrl[phx_pkg::TXT_BYTE_LSB +: 4];
	wire logic [3:0] t_par   = i_ctrl[phx_pkg::TXT_PARITY_LSB +: 4];

	wire logic mode4 = (f_mode == phx_pkg::ENC_MODE_16TO4);
	wire logic mode8 = (f_mode == phx_pkg::ENC_MODE_256TO8);

	// encoder control validity
	wire logic enc_ctrl_ok = (f_dir <= 4'h1) &&
		((mode4 && f_start <= 4'h3 && f_count <= 4'h3) ||
		 (mode8 && f_start <= 4'h1 && f_count <= 4'h1));

	// 16-to-4 path
	logic [3:0]  dig_pos [4];
	logic [3:0]  word_zero;
	logic [15:0] res4;
	logic        zero4;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_word
			assign dig_pos[g]   = pos16(i_src_words[g*16 +: 16], dir_hi);
			assign word_zero[g] = (i_src_words[g*16 +: 16] == phx_pkg::RST_WORD);
		end
	endgenerate

	// each result digit picks the source word that lands on it
	logic [1:0]  dig_src [4];
	logic [3:0]  dig_take;
	logic [3:0]  dig_zero;
	logic [3:0]  res4_dig [4];

	generate
		for (g = 0; g < 4; g++) begin : g_slot4
			assign dig_src[g]  = 2'(4'(g) - f_start);
			assign dig_take[g] = ({2'h0, dig_src[g]} <= f_count);
			assign res4_dig[g] = dig_take[g] ? dig_pos[dig_src[g]] : i_result_prev[g*4 +: 4];
			assign dig_zero[g] = dig_take[g] && word_zero[dig_src[g]];
		end
	endgenerate

	assign res4  = {res4_dig[3], res4_dig[2], res4_dig[1], res4_dig[0]};
	assign zero4 = |dig_zero;

	// 256-to-8 path
	logic [7:0]  rng_pos [2];
	logic [1:0]  rng_zero;
	logic [15:0] res8;
	logic        zero8;

	generate
		for (g = 0; g < 2; g++) begin : g_range
			assign rng_pos[g] = pos256(i_src_words[g*256 +: 256], dir_hi);
			always_comb begin
				rng_zero[g] = 1'b0;
				for (int w = 0; w < 16; w++) begin
					if (i_src_words[g*256 + w*16 +: 16] == phx_pkg::RST_WORD)
						rng_zero[g] = 1'b1;
				end
			end
		end
	endgenerate

	// each result byte picks the range that lands on it
	logic [1:0]  byte_src;
	logic [1:0]  byte_take;
	logic [1:0]  byte_zero;
	logic [7:0]  byte_res [2];

	generate
		for (g = 0; g < 2; g++) begin : g_slot8
			assign byte_src[g]  = 1'(g) ^ f_start[0];
			assign byte_take[g] = ({3'h0, byte_src[g]} <= f_count);
			assign byte_res[g]  = byte_take[g] ? rng_pos[byte_src[g]] : i_result_prev[g*8 +: 8];
			assign byte_zero[g] = byte_take[g] && rng_zero[byte_src[g]];
		end
	endgenerate

	assign res8  = {byte_res[1], byte_res[0]};
	assign zero8 = |byte_zero;

	// converter path
	wire logic txt_ok = (t_digit <= 4'h3) && (t_count <= 4'h3) && (t_byte <= 4'h1) &&
		(t_par <= phx_pkg::PAR_ODD);
	logic [47:0] txt_out;

	// each destination byte picks the digit that lands on it
	logic [3:0]  txt_n   [6];
	logic [5:0]  txt_hit;
	logic [1:0]  txt_sd  [6];
	logic [7:0]  txt_byte [6];

	generate
		for (g = 0; g < 6; g++) begin : g_slot_txt
			assign txt_n[g]    = 4'(g) - {3'h0, t_byte[0]};
			assign txt_hit[g]  = (4'(g) >= {3'h0, t_byte[0]}) && (txt_n[g] <= t_count);
			assign txt_sd[g]   = 2'(t_digit + txt_n[g]);
			assign txt_byte[g] = txt_hit[g] ? to_chr(i_text_src[txt_sd[g]*4 +: 4], t_par)
				: i_dest_prev[g*8 +: 8];
		end
	endgenerate

	assign txt_out = {txt_byte[5], txt_byte[4], txt_byte[3], txt_byte[2], txt_byte[1], txt_byte[0]};

	// answer selection
	wire logic        is_text  = (i_op == phx_pkg::PHX_OP_TEXT);
	wire logic [15:0] enc_res  = mode8 ? res8 : res4;
	wire logic        enc_zero = mode8 ? zero8 : zero4;
	wire logic        err_nxt  = is_text ? !txt_ok : (!enc_ctrl_ok || enc_zero);

	// answer word: new on a request, held otherwise
	logic                 done_r;
	phx_pkg::phx_res_t    res_r;
	phx_pkg::phx_res_t    res_new;
	phx_pkg::phx_res_t    res_nxt;

	assign res_new.err        = err_nxt;
	assign res_new.enc_result = (!is_text && !err_nxt) ? enc_res : i_result_prev;
	assign res_new.txt_words  = (is_text && !err_nxt) ? txt_out : i_dest_prev;
	assign res_nxt            = i_start ? res_new : res_r;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			done_r <= 1'b0;
			res_r  <= '0;
		end else begin
			done_r <= i_start;
			res_r  <= res_nxt;
		end
	end

	assign o_done                  = done_r;
	assign o_result                = res_r.enc_result;
	assign o_dest                  = res_r.txt_words;
	assign o_conversion_error_flag = res_r.err;

endmodule // phx_unit

// [rtl/phx_pkg.sv]
package phx_pkg;

	// operation select
	typedef enum logic {
		PHX_OP_ENCODE,
		PHX_OP_TEXT
	} phx_op_t;

	// control word field positions (encoder)
	localparam int ENC_START_LSB = 0;
	localparam int ENC_COUNT_LSB = 4;
	localparam int ENC_DIR_LSB   = 8;
	localparam int ENC_MODE_LSB  = 12;

	// designator field positions (converter)
	localparam int TXT_DIGIT_LSB  = 0;
	localparam int TXT_COUNT_LSB  = 4;
	localparam int TXT_BYTE_LSB   = 8;
	localparam int TXT_PARITY_LSB = 12;

	// encoder mode codes
	localparam logic [3:0] ENC_MODE_16TO4  = 4'h0;
	localparam logic [3:0] ENC_MODE_256TO8 = 4'h1;

	// parity codes
	localparam logic [3:0] PAR_NONE = 4'h0;
	localparam logic [3:0] PAR_EVEN = 4'h1;
	localparam logic [3:0] PAR_ODD  = 4'h2;

	// character bases
	localparam logic [7:0] CHR_DIGIT_BASE  = 8'h30;
	localparam logic [7:0] CHR_LETTER_BASE = 8'h37;

	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;

	// request: operation, control/designator, operands
	typedef struct packed {
		phx_op_t     op;
		logic [15:0] ctrl;
		logic [15:0] src_text;
		logic [47:0] dst_prev;
	} phx_req_unused_t;

	typedef struct packed {
		logic          err;
		logic [15:0]   enc_result;
		logic [47:0]   txt_words;
	} phx_res_t;

endpackage

// [test/phx_seq_model.sv]
`timescale 1ns/10ps
module phx_seq_model (
	// clock
	input	wire logic	i_ref_clk,
	// word load
	input	wire logic	i_we,
	input	wire logic [4:0]	i_idx,
	input	wire logic [15:0]	i_wd,
	// operand words
	output	logic [511:0]	o_words
);
	logic [15:0]	mem_r [32];
	always_ff @(posedge i_ref_clk) begin
		if (i_we) mem_r[i_idx] <= i_wd;
	end
	always_comb begin
		for (int k = 0; k < 32; k++) o_words[16*k +: 16] = mem_r[k];
	end
endmodule // phx_seq_model

// [test/phx_unit_asserts.sv]
`timescale 1ns/10ps
module phx_unit_asserts (
	// clock, reset, request
	input	wire logic	i_ref_clk,
	input	wire logic	i_sys_rst,
	input	wire logic	i_start,
	input	wire phx_pkg::phx_op_t	i_op,
	input	wire logic [15:0]	i_ctrl,
	input	wire logic [15:0]	i_result_prev,
	input	wire logic [47:0]	i_dest_prev,
	// answer
	input	wire logic	o_done,
	input	wire logic [15:0]	o_result,
	input	wire logic [47:0]	o_dest,
	input	wire logic	o_conversion_error_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	wire	enc_req = i_start && i_op == phx_pkg::PHX_OP_ENCODE;
	wire	txt_req = i_start && i_op == phx_pkg::PHX_OP_TEXT;
	wire	err = o_conversion_error_flag;
	a_done_after_start: assert property (i_start |=> o_done)
		else $error("done missing");
	a_no_stray_done: assert property (!i_start |=> !o_done)
		else $error("stray done");
	a_hold_idle: assert property (!i_start |=> $stable({o_result, o_dest, err}))
		else $error("outputs moved");
	a_bad_mode_err: assert property (enc_req && i_ctrl[15:12] > 4'h1 |=> err)
		else $error("bad mode no error");
	a_bad_dir_err: assert property (enc_req && i_ctrl[11:8] > 4'h1 |=> err)
		else $error("bad direction no error");
	a_bad_parity_err: assert property (txt_req && i_ctrl[15:12] > 4'h2 |=> err)
		else $error("bad parity no error");
	a_text_ok_clear: assert property (txt_req && i_ctrl[15:12] <= 4'h2 && i_ctrl[11:8] <= 4'h1
		&& i_ctrl[7:4] <= 4'h3 && i_ctrl[3:0] <= 4'h3 |=> !err) else $error("error on good designator");
	a_err_keeps_prev: assert property (o_done && err |->
		o_result == $past(i_result_prev) && o_dest == $past(i_dest_prev)) else $error("error changed outputs");
endmodule // phx_unit_asserts
bind phx_unit phx_unit_asserts u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_start(i_start),
	.i_op(i_op), .i_ctrl(i_ctrl), .i_result_prev(i_result_prev), .i_dest_prev(i_dest_prev), .o_done(o_done),
	.o_result(o_result), .o_dest(o_dest), .o_conversion_error_flag(o_conversion_error_flag));

// [test/test_phx_unit.sv]
`timescale 1ns/10ps
module test_phx_unit;
	typedef struct packed {
		phx_pkg::phx_op_t	op;
		logic [15:0]	ctrl;
		logic [47:0]	exp;
	} phx_row_t;
	localparam phx_pkg::phx_op_t	ENC = phx_pkg::PHX_OP_ENCODE;
	localparam phx_pkg::phx_op_t	TXT = phx_pkg::PHX_OP_TEXT;
	logic	i_ref_clk = 1'b0;
	logic	i_sys_rst = 1'b1;
	logic	i_start = 1'b0;
	phx_pkg::phx_op_t	i_op = ENC;
	logic [15:0]	i_ctrl = 16'h0000;
	logic [511:0]	i_src_words;
	logic [47:0]	i_dest_prev = 48'h5a5a5a5a5a5a;
	logic	we = 1'b0;
	logic [4:0]	idx = 5'h00;
	logic [15:0]	wd = 16'h0000;
	logic	o_done;
	logic	o_conversion_error_flag;
	logic [15:0]	o_result;
	logic [47:0]	o_dest;
	int	n_mismatch = 0;
	int	checks_done = 0;
	phx_row_t	rows [8];
	always #12.5 i_ref_clk = ~i_ref_clk;
	phx_seq_model seq (.i_ref_clk(i_ref_clk), .i_we(we), .i_idx(idx), .i_wd(wd), .o_words(i_src_words));
	phx_unit uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op), .i_ctrl(i_ctrl),
		.i_src_words(i_src_words), .i_text_src(16'h9a3c), .i_result_prev(i_dest_prev[15:0]),
		.i_dest_prev(i_dest_prev), .o_done(o_done), .o_result(o_result), .o_dest(o_dest),
		.o_conversion_error_flag(o_conversion_error_flag));
	task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task ld(input logic [4:0] k, input logic [15:0] v);
		@(posedge i_ref_clk);
		we <= 1'b1;
		idx <= k;
		wd <= v;
		@(posedge i_ref_clk);
		we <= 1'b0;
	endtask
	// one request, checked just after the answering edge
	task go(input phx_pkg::phx_op_t op, input logic [15:0] c, input logic e);
		@(posedge i_ref_clk);
		i_start <= 1'b1;
		i_op <= op;
		i_ctrl <= c;
		@(posedge i_ref_clk);
		i_start <= 1'b0;
		#1;
		chk("flag", 48'(o_conversion_error_flag), 48'(e));
		chk("done", 48'(o_done), 48'h1);
	endtask
	initial begin
		repeat (4000) @(posedge i_ref_clk);
		n_mismatch++;
		close_out();
	end
	initial begin
		rows[0] = '{ENC, 16'h0021, 48'h210a};
		rows[1] = '{ENC, 16'h0133, 48'hf321};
		rows[2] = '{ENC, 16'h1101, 48'hff5a};
		rows[3] = '{ENC, 16'h1011, 48'h0004};
		rows[4] = '{TXT, 16'h0121, 48'h5a5a3941335a};
		rows[5] = '{TXT, 16'h1030, 48'h5a5a394133c3};
		rows[6] = '{TXT, 16'h2032, 48'h5a5ab343b9c1};
		rows[7] = '{TXT, 16'h0133, 48'h5a413343395a};
		repeat (12) @(posedge i_ref_clk);
		#1;
		chk("rst_dest", o_dest, 48'h0);
		chk("rst_res", 48'(o_result), 48'h0);
		chk("rst_flag", 48'(o_conversion_error_flag), 48'h0);
		chk("rst_done", 48'(o_done), 48'h0);
		@(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		$display("reset done");
		for (int k = 0; k < 32; k++) ld(5'(k), k == 0 ? 16'h8001 : k == 16 ? 16'h0030 : 16'h0001 << (k % 16));
		foreach (rows[n]) begin
			go(rows[n].op, rows[n].ctrl, 1'b0);
			if (rows[n].op == ENC) chk("res", 48'(o_result), {32'h0, rows[n].exp[15:0]});
			else chk("dest", o_dest, rows[n].exp);
		end
		$display("table done");
		go(ENC, 16'h2000, 1'b1);
		chk("keep", 48'(o_result), 48'h5a5a);
		go(ENC, 16'h0200, 1'b1);
		go(TXT, 16'h3000, 1'b1);
		chk("keep_d", o_dest, i_dest_prev);
		$display("bad control done");
		ld(5'd2, 16'h0000);
		go(ENC, 16'h0020, 1'b1);
		go(ENC, 16'h0010, 1'b0);
		chk("res2", 48'(o_result), 48'h5a10);
		go(ENC, 16'h1000, 1'b1);
		$display("zero word done");
		close_out();
	end
endmodule // test_phx_unit
